// File: dbdi_pkg.sv
/*
  constants, address map and helpers for the display board decode and
  interrupt glue. assumes an 8-bit local processor bus with 16-bit
  addresses and single-cycle read and write strobes.
*/
// Contract
// - program memory at 0000-07FF, scratch RAM at 1000-13FF.
// - scratch RAM is one kilobyte, processor use only.
// - 2K dual-port video memory at 2000-27FF; display only reads it.
// - any access to 3000 raises a reset toward the host board.
// - peripheral RAM 4000-40FF, ports 4800-4803, timer 4804-4805.
// - host serial interface selected at 5000-5001.
// - everything memory mapped; bell at 6000, display controller 7000-7001.
// - rank vsync, host rx, utility rx, keyboard rx, host tx.
// - keyboard strobe latches byte, then interrupt and data-ready flag rise.
// - keyboard data-ready flag can be polled by the processor.
// - after power up the first 2K answers as program memory.
// - board drives the serial clock toward the host board.
// - keyboard port: eight data bits, strobe in, ready out.
// - utility port repeats the keyboard handshake for a second keyboard.
// - character generator addresses glyphs on an 8 x 12 matrix.
// - keyboard reset request only passes on to the host board.
package dbdi_pkg;

  // ==========================================================
  // address map
  localparam logic [15:0] PROG_LO = 16'h0000;
  localparam logic [15:0] PROG_HI = 16'h07FF;
  localparam logic [15:0] SCR_LO = 16'h1000;
  localparam logic [15:0] SCR_HI = 16'h13FF;
  localparam logic [15:0] VID_LO = 16'h2000;
  localparam logic [15:0] VID_HI = 16'h27FF;
  localparam logic [15:0] HRST_ADDR = 16'h3000;
  localparam logic [15:0] PRAM_LO = 16'h4000;
  localparam logic [15:0] PRAM_HI = 16'h40FF;
  localparam logic [15:0] PIO_LO = 16'h4800;
  localparam logic [15:0] PIO_HI = 16'h4803;
  localparam logic [15:0] TMR_LO = 16'h4804;
  localparam logic [15:0] TMR_HI = 16'h4805;
  localparam logic [15:0] SER_LO = 16'h5000;
  localparam logic [15:0] SER_HI = 16'h5001;
  localparam logic [15:0] BELL_ADDR = 16'h6000;
  localparam logic [15:0] DISP_LO = 16'h7000;
  localparam logic [15:0] DISP_HI = 16'h7001;

  // ==========================================================
  // memory sizes
  localparam int SCR_AW = 10;
  localparam int VID_AW = 11;

  // ==========================================================
  // parallel port registers, index within 4800-4803
  localparam logic [1:0] PREG_STATUS = 2'h0;
  localparam logic [1:0] PREG_KBD = 2'h1;
  localparam logic [1:0] PREG_UTIL = 2'h2;
  localparam logic [1:0] PREG_CTRL = 2'h3;
  localparam int ST_KBD_BIT = 0;
  localparam int ST_UTIL_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // ==========================================================
  // glyph matrix and interrupt codes
  localparam int GLYPH_COLS = 8;
  localparam logic [3:0] GLYPH_ROWS = 4'hC;
  localparam logic [2:0] IRQ_NONE = 3'h0;
  localparam logic [2:0] IRQ_VSYNC = 3'h1;
  localparam logic [2:0] IRQ_HOST_RX = 3'h2;
  localparam logic [2:0] IRQ_UTIL_RX = 3'h3;
  localparam logic [2:0] IRQ_KBD_RX = 3'h4;
  localparam logic [2:0] IRQ_HOST_TX = 3'h5;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int HRST_NS = 1000;
  localparam int HRST_CYC = (HRST_NS * CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ) / 1000;

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// File: dbdi_port_if.sv
/*
  carrier between the strobed parallel channel and the decode core.
  assumes one clock domain; pins are synchronous to sys_clk.
*/
`timescale 1ns/10ps
interface dbdi_port_if;
  logic strobe; // pin strobe from the keyboard
  logic [7:0] pin_data; // pin data bits
  logic ready; // transmit enable back to the keyboard
  logic full; // byte waiting for the processor
  logic [7:0] held; // latched byte
  logic take; // processor read of the byte

  modport chan (input strobe, input pin_data, input take,
                output ready, output full, output held);
  modport core (output strobe, output pin_data, output take,
                input ready, input full, input held);
endinterface

// File: dbdi_port.sv
/*
  one strobed input channel: latches a byte on the strobe's rising
  edge and holds a data-ready flag until the processor reads it.
  assumes the strobe is a clean level synchronous to sys_clk.
*/
`timescale 1ns/10ps
module dbdi_port (
  input wire logic sys_clk, // board clock
  input wire logic rst, // async reset, active high
  dbdi_port_if.chan p // pin and core side
);
  import dbdi_pkg::*;

  logic stb_q;
  logic full_q;
  logic full_d;
  logic [7:0] held_q;
  wire stb_rise = p.strobe & ~stb_q;
  // a byte offered while full is dropped; ready is low then anyway
  wire accept = stb_rise & ~full_q;

  // =========================================================
  // flag: a new byte in the same cycle as the read wins
  assign full_d = accept ? 1'b1 : (p.take ? 1'b0 : full_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stb_q <= 1'b0;
      full_q <= 1'b0;
      held_q <= 8'h00;
    end else begin
      stb_q <= p.strobe;
      full_q <= full_d;
      if (accept) begin
        held_q <= p.pin_data;
      end
    end
  end

  // ready tells the keyboard it may send the next byte
  assign p.ready = ~full_q;
  assign p.full = full_q;
  assign p.held = held_q;
endmodule

// File: dbdi_top.sv
/*
  display board glue: address decode, scratch and video memories,
  host reset and serial clock, two parallel channels and interrupt
  ranking. assumes the processor presents address and data with
  one-cycle read or write strobes; read data returns a cycle later.
*/
`timescale 1ns/10ps
module dbdi_top (
  input wire logic sys_clk, // board clock, 250 MHz
  input wire logic rst, // async reset, active high
  input wire logic [15:0] cpu_addr, // processor address
  input wire logic cpu_rd, // read strobe
  input wire logic cpu_wr, // write strobe
  input wire logic [7:0] cpu_wdata, // write data
  output logic [7:0] cpu_rdata, // read data, valid after rd
  input wire logic [7:0] ext_rdata, // data from outside devices
  output logic prog_sel, // program memory select
  output logic pram_sel, // peripheral RAM select
  output logic timer_sel, // baud timer select
  output logic serial_sel, // host serial interface select
  output logic display_sel, // display controller select
  output logic bell_pulse, // bell trigger pulse
  input wire logic kbd_rst_req, // reset request from keyboard
  output logic host_rst, // reset toward host board
  output logic host_sclk, // serial clock to host board
  input wire logic [dbdi_pkg::VID_AW-1:0] disp_addr, // refresh read address
  input wire logic [3:0] glyph_row, // scan row in the glyph
  output logic [11:0] chargen_addr, // character generator address
  input wire logic kbd_strobe, // keyboard data available
  input wire logic [7:0] kbd_data, // keyboard data pins
  output logic kbd_ready, // keyboard transmit enable
  input wire logic util_strobe, // utility data available
  input wire logic [7:0] util_data, // utility data pins
  output logic util_ready, // utility transmit enable
  input wire logic vsync, // vertical sync event
  input wire logic host_rx_irq, // host serial receive ready
  input wire logic host_tx_irq, // host serial transmit ready
  output logic irq_req, // an interrupt is pending
  output logic [2:0] irq_code // rank of presented source
);
  import dbdi_pkg::*;

  // ==========================================================
  // address decode
  wire acc = cpu_rd | cpu_wr;
  wire hit_prog = in_range(cpu_addr, PROG_LO, PROG_HI);
  wire hit_scr = in_range(cpu_addr, SCR_LO, SCR_HI);
  wire hit_vid = in_range(cpu_addr, VID_LO, VID_HI);
  wire hit_hrst = (cpu_addr == HRST_ADDR);
  wire hit_pram = in_range(cpu_addr, PRAM_LO, PRAM_HI);
  wire hit_pio = in_range(cpu_addr, PIO_LO, PIO_HI);
  wire hit_tmr = in_range(cpu_addr, TMR_LO, TMR_HI);
  wire hit_ser = in_range(cpu_addr, SER_LO, SER_HI);
  wire hit_bell = (cpu_addr == BELL_ADDR);
  wire hit_disp = in_range(cpu_addr, DISP_LO, DISP_HI);
  // unmapped reads return zero rather than whatever floats outside
  wire hit_ext = hit_prog | hit_pram | hit_tmr | hit_ser | hit_disp;
  wire [1:0] pio_idx = cpu_addr[1:0];

  // selects toward outside devices; no remap, so reset fetches hit prog
  assign prog_sel = acc & hit_prog;
  assign pram_sel = acc & hit_pram;
  assign timer_sel = acc & hit_tmr;
  assign serial_sel = acc & hit_ser;
  assign display_sel = acc & hit_disp;

  // ==========================================================
  // scratch memory, 1K, processor only
  logic [7:0] scr_mem [0:(1<<SCR_AW)-1];
  logic [7:0] scr_q;
  wire [SCR_AW-1:0] scr_a = cpu_addr[SCR_AW-1:0];

  // no reset on the array: it only holds processor scratch data
  always_ff @(posedge sys_clk) begin
    if (cpu_wr && hit_scr) begin
      scr_mem[scr_a] <= cpu_wdata;
    end
    scr_q <= scr_mem[scr_a];
  end

  // ==========================================================
  // video memory, 2K, two ports
  logic [7:0] vid_mem [0:(1<<VID_AW)-1];
  logic [7:0] vid_q;
  logic [7:0] disp_q;
  wire [VID_AW-1:0] vid_a = cpu_addr[VID_AW-1:0];

  // processor port reads and writes, refresh port only reads
  always_ff @(posedge sys_clk) begin
    if (cpu_wr && hit_vid) begin
      vid_mem[vid_a] <= cpu_wdata;
    end
    vid_q <= vid_mem[vid_a];
    disp_q <= vid_mem[disp_addr];
  end

  // ==========================================================
  // character generator address: code times twelve rows plus row
  logic [11:0] cg_q;
  logic [11:0] cg_d;
  wire [3:0] row_c = (glyph_row < GLYPH_ROWS) ? glyph_row : 4'h0;
  // rows past the glyph height fold to row zero, a blank scan line
  assign cg_d = 12'({disp_q[6:0], 3'h0}) + 12'({disp_q[6:0], 2'h0})
                + 12'(row_c);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cg_q <= 12'h000;
    end else begin
      cg_q <= cg_d;
    end
  end
  assign chargen_addr = cg_q;

  // ==========================================================
  // host reset: one fixed pulse per access or keyboard request
  logic [$clog2(HRST_CYC+1)-1:0] hrst_cnt_q;
  logic [$clog2(HRST_CYC+1)-1:0] hrst_cnt_d;
  logic host_rst_q;
  wire hrst_trig = (acc & hit_hrst) | kbd_rst_req;
  wire hrst_busy = (hrst_cnt_q != '0);

  // a trigger during the pulse is absorbed, it does not stretch it
  assign hrst_cnt_d = (hrst_trig && !hrst_busy) ?
                      $bits(hrst_cnt_q)'(HRST_CYC) :
                      (hrst_busy ? hrst_cnt_q - 1'b1 : hrst_cnt_q);

  // keyboard request never touches rst of this board, only the pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrst_cnt_q <= '0;
      host_rst_q <= 1'b0;
    end else begin
      hrst_cnt_q <= hrst_cnt_d;
      host_rst_q <= (hrst_cnt_d != '0);
    end
  end
  assign host_rst = host_rst_q;

  // ==========================================================
  // serial clock to the host board, free running divider
  logic [$clog2(SCLK_HALF_CYC)-1:0] sclk_cnt_q;
  logic sclk_q;
  wire sclk_wrap = (sclk_cnt_q == $bits(sclk_cnt_q)'(SCLK_HALF_CYC-1));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_cnt_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      sclk_cnt_q <= sclk_wrap ? '0 : sclk_cnt_q + 1'b1;
      if (sclk_wrap) begin
        sclk_q <= ~sclk_q;
      end
    end
  end
  assign host_sclk = sclk_q;

  // ==========================================================
  // bell: one-cycle trigger on any access
  logic bell_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bell_q <= 1'b0;
    end else begin
      bell_q <= acc & hit_bell;
    end
  end
  assign bell_pulse = bell_q;

  // ==========================================================
  // parallel channels
  dbdi_port_if kbd_if ();
  dbdi_port_if util_if ();

  // reading a data byte frees the channel for the next one
  assign kbd_if.strobe = kbd_strobe;
  assign kbd_if.pin_data = kbd_data;
  assign kbd_if.take = cpu_rd & hit_pio & (pio_idx == PREG_KBD);
  assign util_if.strobe = util_strobe;
  assign util_if.pin_data = util_data;
  assign util_if.take = cpu_rd & hit_pio & (pio_idx == PREG_UTIL);

  dbdi_port u_kbd (
    .sys_clk (sys_clk),
    .rst (rst),
    .p (kbd_if.chan)
  );

  dbdi_port u_util (
    .sys_clk (sys_clk),
    .rst (rst),
    .p (util_if.chan)
  );

  assign kbd_ready = kbd_if.ready;
  assign util_ready = util_if.ready;

  // ==========================================================
  // port control register: interrupt enables per channel
  logic [1:0] ctrl_q;

  // polling works with enables cleared, the flags still show
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (cpu_wr && hit_pio && pio_idx == PREG_CTRL) begin
      ctrl_q <= cpu_wdata[1:0];
    end
  end

  wire [7:0] pio_status = {6'h00, util_if.full, kbd_if.full};
  wire kbd_rx_irq = kbd_if.full & ctrl_q[ST_KBD_BIT];
  wire util_rx_irq = util_if.full & ctrl_q[ST_UTIL_BIT];

  // ==========================================================
  // read data return
  logic [2:0] rsrc_q;
  logic [1:0] ridx_q;
  logic [7:0] rdata_q;
  logic [7:0] pio_rd;

  // one cycle of memory latency, so remember where the read went
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsrc_q <= 3'h0;
      ridx_q <= 2'h0;
    end else begin
      rsrc_q <= !cpu_rd ? 3'h0 : hit_scr ? 3'h1 : hit_vid ? 3'h2 :
                hit_pio ? 3'h3 : hit_ext ? 3'h4 : 3'h0;
      ridx_q <= pio_idx;
    end
  end

  // port register captured in the read cycle so a clearing read still sees it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pio_rd <= 8'h00;
    end else begin
      unique case (pio_idx)
        PREG_STATUS: pio_rd <= pio_status;
        PREG_KBD: pio_rd <= kbd_if.held;
        PREG_UTIL: pio_rd <= util_if.held;
        PREG_CTRL: pio_rd <= {6'h00, ctrl_q};
      endcase
    end
  end

  always_comb begin
    unique case (rsrc_q)
      3'h1: rdata_q = scr_q;
      3'h2: rdata_q = vid_q;
      3'h3: rdata_q = pio_rd;
      3'h4: rdata_q = ext_rdata;
      default: rdata_q = 8'h00;
    endcase
  end
  assign cpu_rdata = rdata_q;

  // ==========================================================
  // interrupt ranking, lowest code wins
  logic [2:0] irq_d;
  logic [2:0] irq_q;

  assign irq_d = vsync ? IRQ_VSYNC :
                 host_rx_irq ? IRQ_HOST_RX :
                 util_rx_irq ? IRQ_UTIL_RX :
                 kbd_rx_irq ? IRQ_KBD_RX :
                 host_tx_irq ? IRQ_HOST_TX : IRQ_NONE;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q <= IRQ_NONE;
    end else begin
      irq_q <= irq_d;
    end
  end
  assign irq_code = irq_q;
  assign irq_req = (irq_q != IRQ_NONE);
endmodule

// File: dbdi_key_src.sv
/*
  model of a keyboard on one strobed parallel channel.
  assumes the design's ready line and one clock domain.
*/
`timescale 1ns/10ps
module dbdi_key_src (
  input wire logic sys_clk, // board clock
  input wire logic ready, // transmit enable from the board
  input wire logic go, // send request from the bench
  input wire logic [7:0] byte_in, // byte to send
  input wire logic [2:0] len, // strobe length in cycles, 1..7
  output logic strobe = 1'b0, // data available
  output logic [7:0] data = 8'h00 // data pins
);
  logic [2:0] cnt_q = 3'h0;

  // ========================================
  // strobe starts only while the board is ready; pins flip once released
  always @(posedge sys_clk) begin
    if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) begin
        strobe <= 1'b0;
        data <= ~data; // stale byte never lingers on the pins
      end
    end else if (go && ready) begin
      strobe <= 1'b1;
      data <= byte_in;
      cnt_q <= len;
    end
  end
endmodule

// File: dbdi_top_monitor.sv
/*
  concurrent checks on the display board glue top ports.
  assumes binding into dbdi_top, single clock domain.
*/
`timescale 1ns/10ps
module dbdi_top_monitor (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic [15:0] cpu_addr, // address
  input wire logic cpu_rd, // read
  input wire logic cpu_wr, // write
  input wire logic [7:0] cpu_rdata, // read data
  input wire logic prog_sel, // program
  input wire logic pram_sel, // periph ram
  input wire logic serial_sel, // serial
  input wire logic display_sel, // display
  input wire logic bell_pulse, // bell
  input wire logic kbd_rst_req, // key reset
  input wire logic host_rst, // host reset
  input wire logic kbd_strobe, // key strobe
  input wire logic kbd_ready, // key ready
  input wire logic vsync, // vsync
  input wire logic host_rx_irq, // host rx
  input wire logic irq_req, // irq pending
  input wire logic [2:0] irq_code // irq rank
);
  import dbdi_pkg::*;
  wire acc = cpu_rd || cpu_wr;
  logic [8:0] hlen_q;

  // ========================================
  // host reset length; a counter avoids a long repetition
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) hlen_q <= 9'h000;
    else hlen_q <= host_rst ? hlen_q + 9'h001 : 9'h000;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ========================================
  // decode, pulses and interrupt ranking
  prog_sel_a: assert property (
    prog_sel == (acc && cpu_addr <= PROG_HI))
    else $error("program select wrong");
  pram_sel_a: assert property (
    pram_sel == (acc && cpu_addr >= PRAM_LO && cpu_addr <= PRAM_HI))
    else $error("peripheral ram select wrong");
  serial_sel_a: assert property (
    serial_sel == (acc && cpu_addr[15:1] == 15'h2800))
    else $error("serial select wrong");
  display_sel_a: assert property (
    display_sel == (acc && cpu_addr[15:1] == 15'h3800))
    else $error("display select wrong");
  bell_pulse_a: assert property (
    acc && cpu_addr == BELL_ADDR |=> bell_pulse)
    else $error("bell missed");
  host_start_a: assert property (
    acc && cpu_addr == HRST_ADDR && !host_rst |=> host_rst)
    else $error("host reset missed");
  host_len_a: assert property (
    $fell(host_rst) |-> hlen_q == HRST_CYC)
    else $error("host reset length wrong");
  key_reset_a: assert property (
    kbd_rst_req && !host_rst |=> host_rst)
    else $error("key reset not passed on");
  key_take_a: assert property (
    $rose(kbd_strobe) && kbd_ready |=> !kbd_ready)
    else $error("key byte not taken");
  key_poll_a: assert property (
    cpu_rd && cpu_addr == 16'h4801 && !kbd_strobe |=> kbd_ready)
    else $error("key flag not cleared");
  vsync_top_a: assert property (
    vsync |=> irq_code == IRQ_VSYNC)
    else $error("vsync not ranked first");
  host_rx_a: assert property (
    host_rx_irq && !vsync |=> irq_code == IRQ_HOST_RX)
    else $error("host rx not ranked second");
  irq_req_a: assert property (
    irq_req == (irq_code != IRQ_NONE))
    else $error("request and code disagree");
  unmapped_rd_a: assert property (
    cpu_rd && cpu_addr[15] |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");

  c_host: cover property ($rose(host_rst));
  c_bell: cover property (bell_pulse);
  c_key: cover property ($rose(kbd_strobe) && kbd_ready);
  c_vsync: cover property (irq_code == IRQ_VSYNC);
endmodule

bind dbdi_top dbdi_top_monitor dbdi_top_monitor_inst (.sys_clk(sys_clk),
  .rst(rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
  .cpu_rdata(cpu_rdata), .prog_sel(prog_sel), .pram_sel(pram_sel),
  .serial_sel(serial_sel), .display_sel(display_sel),
  .bell_pulse(bell_pulse), .kbd_rst_req(kbd_rst_req), .host_rst(host_rst),
  .kbd_strobe(kbd_strobe), .kbd_ready(kbd_ready), .vsync(vsync),
  .host_rx_irq(host_rx_irq), .irq_req(irq_req), .irq_code(irq_code));

// File: testbench.sv
/*
  self-checking bench for the display board glue with two keyboards.
  assumes dbdi_pkg, dbdi_top and the keyboard model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  import dbdi_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, cpu_rd = 1'b0, cpu_wr = 1'b0;
  logic [15:0] cpu_addr = 16'h0000, a;
  logic [7:0] cpu_wdata = 8'h00, ext_rdata = 8'h00, cpu_rdata, rd_seen, b1, b2;
  logic kbd_rst_req = 1'b0, vsync = 1'b0, host_rx_irq = 1'b0;
  logic host_tx_irq = 1'b0, kbd_go = 1'b0, util_go = 1'b0, bell_seen;
  logic [VID_AW-1:0] disp_addr = '0;
  logic [3:0] glyph_row = 4'h0;
  logic [7:0] go_byte = 8'h00, kbd_data, util_data;
  logic [2:0] go_len = 3'h1, irq_code;
  wire [4:0] sel;
  logic [4:0] sel_seen;
  logic bell_pulse, host_rst, host_sclk, irq_req, kbd_strobe, util_strobe;
  logic kbd_ready, util_ready;
  logic [11:0] chargen_addr;
  logic [15:0] corner [12] = '{16'h07ff, 16'h0800, 16'h3fff, 16'h40ff,
    16'h4100, 16'h4803, 16'h4806, 16'h5001, 16'h5002, 16'h6000, 16'h7002,
    16'hffff};
  logic [15:0] ram_a [4] = '{16'h1000, 16'h13ff, 16'h2000, 16'h27ff};
  logic [7:0] ram_d [4];
  int fails = 0, tests_run = 0, cyc = 0, n;

  dbdi_top dbdi_top_inst (.sys_clk(sys_clk), .rst(rst), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .ext_rdata(ext_rdata), .prog_sel(sel[4]),
    .pram_sel(sel[3]), .timer_sel(sel[2]), .serial_sel(sel[1]),
    .display_sel(sel[0]), .bell_pulse(bell_pulse), .kbd_rst_req(kbd_rst_req),
    .host_rst(host_rst), .host_sclk(host_sclk), .disp_addr(disp_addr),
    .glyph_row(glyph_row), .chargen_addr(chargen_addr),
    .kbd_strobe(kbd_strobe), .kbd_data(kbd_data), .kbd_ready(kbd_ready),
    .util_strobe(util_strobe), .util_data(util_data),
    .util_ready(util_ready), .vsync(vsync), .host_rx_irq(host_rx_irq),
    .host_tx_irq(host_tx_irq), .irq_req(irq_req), .irq_code(irq_code));
  dbdi_key_src dbdi_key_src_inst (.sys_clk(sys_clk), .ready(kbd_ready),
    .go(kbd_go), .byte_in(go_byte), .len(go_len), .strobe(kbd_strobe),
    .data(kbd_data));
  dbdi_key_src util_src_inst (.sys_clk(sys_clk), .ready(util_ready),
    .go(util_go), .byte_in(go_byte), .len(go_len), .strobe(util_strobe),
    .data(util_data));

  // ========================================
  // clock and hang guard; the run needs under 3000 cycles
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      results();
    end
  end

  // ========================================
  // expectations
  function automatic logic [4:0] exp_sel(input logic [15:0] x);
    return {x <= PROG_HI, x >= PRAM_LO && x <= PRAM_HI,
      x == TMR_LO || x == TMR_HI, x == SER_LO || x == SER_HI,
      x == DISP_LO || x == DISP_HI};
  endfunction
  function automatic logic [2:0] prio(input logic [4:0] s);
    return s[4] ? IRQ_VSYNC : s[3] ? IRQ_HOST_RX : s[2] ? IRQ_UTIL_RX :
      s[1] ? IRQ_KBD_RX : s[0] ? IRQ_HOST_TX : IRQ_NONE;
  endfunction

  // ========================================
  // bus cycle, comparison and closing
  task automatic acc(input logic w, input logic [15:0] x, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= x;
    cpu_rd <= !w;
    cpu_wr <= w;
    cpu_wdata <= d;
    ext_rdata <= 8'($urandom);
    #1 sel_seen = sel;
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    #1 rd_seen = cpu_rdata;
    bell_seen = bell_pulse;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", s, e, g);
      fails++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic hcount();
    n = 0;
    repeat (300) begin
      if (host_rst === 1'b1) n++;
      tick(1);
    end
  endtask
  task automatic gap();
    logic s;
    s = host_sclk;
    n = 0;
    while (host_sclk === s && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  task automatic send(input logic u, input logic [7:0] b);
    @(posedge sys_clk);
    go_byte <= b;
    go_len <= 3'($urandom_range(1, 7));
    if (u) util_go <= 1'b1;
    else kbd_go <= 1'b1;
    @(posedge sys_clk);
    kbd_go <= 1'b0;
    util_go <= 1'b0;
    n = 0;
    while ((u ? util_ready : kbd_ready) !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ========================================
  // main sequence
  initial begin
    void'($urandom(32'h61f5));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    chk("ready after reset", 1, kbd_ready);
    for (int i = 0; i < 172; i++) begin
      a = (i < 12) ? corner[i] : {1'b0, 3'($urandom),
        ($urandom % 2) ? 12'($urandom % 8) : 12'($urandom)};
      if (a == HRST_ADDR) a = 16'h3001;
      acc(1'b0, a, 8'h00);
      chk("selects", exp_sel(a), sel_seen);
      chk("bell", a == BELL_ADDR, bell_seen);
      if (exp_sel(a) != 5'h00) chk("ext read", ext_rdata, rd_seen);
      else if (a[15]) chk("unmapped read", 0, rd_seen);
    end
    foreach (ram_a[i]) begin
      ram_d[i] = 8'($urandom);
      acc(1'b1, ram_a[i], ram_d[i]);
    end
    foreach (ram_a[i]) begin
      acc(1'b0, ram_a[i], 8'h00);
      chk("ram", ram_d[i], rd_seen);
    end
    acc(1'b0, 16'h1400, 8'h00);
    chk("past scratch end", 0, rd_seen);
    for (int r = 11; r < 13; r++) begin
      b1 = 8'($urandom);
      a = 16'($urandom % 2048);
      acc(1'b1, VID_LO + a, b1);
      @(posedge sys_clk);
      disp_addr <= a[10:0];
      glyph_row <= 4'(r);
      tick(2);
      chk("glyph", 12'(b1[6:0]) * 12'(GLYPH_ROWS)
        + ((r < GLYPH_ROWS) ? r : 0), chargen_addr);
    end
    acc(1'b1, HRST_ADDR, 8'h00);
    hcount();
    chk("host reset len", HRST_CYC, n);
    @(posedge sys_clk) kbd_rst_req <= 1'b1;
    @(posedge sys_clk) kbd_rst_req <= 1'b0;
    #1 hcount();
    chk("key reset len", HRST_CYC, n);
    gap();
    gap();
    chk("serial clock half", SCLK_HALF_CYC, n);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      {vsync, host_rx_irq, host_tx_irq} <= 3'(i);
      tick(1);
      chk("irq rank", prio({i[2], i[1], 2'b00, i[0]}), irq_code);
      chk("irq req", i != 0, irq_req);
    end
    @(posedge sys_clk);
    {vsync, host_rx_irq, host_tx_irq} <= 3'h1;
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    send(1'b0, b1);
    send(1'b1, b2);
    tick(2);
    chk("irq both full", prio(5'b00111), irq_code);
    acc(1'b0, PIO_LO, 8'h00);
    chk("status", 2'b11, rd_seen[1:0]);
    acc(1'b0, 16'h4802, 8'h00);
    chk("util byte", b2, rd_seen);
    tick(1);
    chk("util ready", 1, util_ready);
    chk("irq key full", prio(5'b00011), irq_code);
    // enables cleared: no keyboard interrupt, but the flag still polls
    acc(1'b1, 16'h4803, 8'h00);
    tick(1);
    chk("irq masked", prio(5'b00001), irq_code);
    acc(1'b0, PIO_LO, 8'h00);
    chk("polled flag", 2'b01, rd_seen[1:0]);
    acc(1'b1, 16'h4803, 8'h03);
    acc(1'b0, 16'h4801, 8'h00);
    chk("key byte", b1, rd_seen);
    tick(1);
    chk("key ready", 1, kbd_ready);
    chk("irq tx only", prio(5'b00001), irq_code);
    acc(1'b0, PIO_LO, 8'h00);
    chk("status empty", 0, rd_seen[1:0]);
    results();
  end
endmodule
